//--- verilog/lsd_fault_logic.sv
// Low-side driver command, filtering and fault latching behind Wishbone
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ns

// -----------------------------------------------------------------------------
// Level filter: output follows input after N stable differing cycles
// -----------------------------------------------------------------------------
module lsd_level_filter
  import lsd_pkg::*;
#(
  parameter int N = 2
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic level_in,
  output logic      level_out
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(N - 1);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_r     <= '0;
      level_out <= 1'b0;
    end
    else if (level_in == level_out)
      cnt_r <= '0;
    else if (cnt_r == LAST)
    begin
      cnt_r     <= '0;
      level_out <= level_in;
    end
    else
      cnt_r <= cnt_r + CNT_W'(1);
  end
endmodule // lsd_level_filter

module lsd_fault_logic
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          overcurrent_cmp,
  input  wire logic          overtemp_cmp,
  input  wire logic          drain_above_cmp,
  output logic               resistive_load_output
);
  import lsd_pkg::*;

  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic       oc_s;
  logic       ot_s;
  logic       drain_s;
  logic       oc_filt;
  logic       ot_filt;
  logic       drain_state_bit;
  logic       open_in;
  logic       open_filt;
  logic       output_on_cmd_r;
  logic       output_on_cmd_nxt;
  logic       open_load_flag_r;
  logic       overcurrent_flag_r;
  logic       overtemp_flag_r;
  logic       req;
  logic       wr_go;
  logic       ctrl_wr;
  logic       fault_clear_cmd;
  logic [31:0] rd_nxt;

  // ---------------------------------------------------------------------------
  // Comparator synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {drain_above_cmp, overtemp_cmp, overcurrent_cmp};
      sync_r <= meta_r;
    end
  end

  assign oc_s    = sync_r[0];
  assign ot_s    = sync_r[1];
  assign drain_s = sync_r[2];
  // Filter held in reset while on or loaded: no partial count survives,
  // and a reconnected load drops the condition at once instead of after T2
  assign open_in = ~drain_s & ~resistive_load_output; // R3

  // ---------------------------------------------------------------------------
  // Filters
  // ---------------------------------------------------------------------------
  lsd_level_filter #(.N(SHORT_CYC)) u_oc_filt (  // R5
    .clk       (clk),
    .sys_rst   (sys_rst),
    .level_in  (oc_s),
    .level_out (oc_filt)
  );
  lsd_level_filter #(.N(SHORT_CYC)) u_ot_filt (  // R8
    .clk       (clk),
    .sys_rst   (sys_rst),
    .level_in  (ot_s),
    .level_out (ot_filt)
  );
  lsd_level_filter #(.N(SHORT_CYC)) u_drain_filt (  // R4
    .clk       (clk),
    .sys_rst   (sys_rst),
    .level_in  (drain_s),
    .level_out (drain_state_bit)
  );
  lsd_level_filter #(.N(LONG_CYC)) u_open_filt (  // R2
    .clk       (clk),
    .sys_rst   (sys_rst | ~open_in), // R3
    .level_in  (open_in),
    .level_out (open_filt)
  );

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  assign req             = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_go           = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign ctrl_wr         = wr_go & (wb_adr_i == CTRL_OFS);
  assign fault_clear_cmd = ctrl_wr & wb_dat_i[CLR_BIT];

  always_comb
  begin
    rd_nxt = '0;
    if (wb_adr_i == CTRL_OFS)
      rd_nxt[ON_BIT] = output_on_cmd_r;
    else if (wb_adr_i == STAT_OFS)
    begin
      rd_nxt[OPEN_BIT]  = open_load_flag_r;
      rd_nxt[OC_BIT]    = overcurrent_flag_r;
      rd_nxt[OT_BIT]    = overtemp_flag_r;
      rd_nxt[DRAIN_BIT] = drain_state_bit;
      rd_nxt[OUT_BIT]   = resistive_load_output;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Command and fault latches
  // ---------------------------------------------------------------------------
  always_comb
  begin
    output_on_cmd_nxt = output_on_cmd_r;
    if (oc_filt | ot_filt)
      output_on_cmd_nxt = 1'b0; // R6
    else if (ctrl_wr & ~(overcurrent_flag_r | overtemp_flag_r))
      output_on_cmd_nxt = wb_dat_i[ON_BIT]; // R1 R10
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      output_on_cmd_r       <= ON_RST;
      resistive_load_output <= ON_RST;
    end
    else
    begin
      output_on_cmd_r       <= output_on_cmd_nxt;
      resistive_load_output <= output_on_cmd_nxt; // R1
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      open_load_flag_r   <= FLAG_RST;
      overcurrent_flag_r <= FLAG_RST;
      overtemp_flag_r    <= FLAG_RST;
    end
    else
    begin
      open_load_flag_r   <= open_filt | (open_load_flag_r & ~fault_clear_cmd); // R2
      overcurrent_flag_r <= oc_filt | (overcurrent_flag_r & ~fault_clear_cmd); // R5 R10
      overtemp_flag_r    <= ot_filt | (overtemp_flag_r & ~fault_clear_cmd); // R8 R9
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] oc_run_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst | ~oc_s)
      oc_run_r <= '0;
    else if (oc_run_r != '1)
      oc_run_r <= oc_run_r + CNT_W'(1);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_on_write_drives: assert property ( // R1
    ctrl_wr && wb_dat_i[ON_BIT] && !oc_filt && !ot_filt
    && !overcurrent_flag_r && !overtemp_flag_r |=> resistive_load_output)
    else $error("on write did not drive output");
  a_out_rise_cause: assert property ( // R1
    $rose(resistive_load_output) |-> $past(ctrl_wr && wb_dat_i[ON_BIT]))
    else $error("output rose without on write");
  a_open_needs_off: assert property ( // R3
    $rose(open_load_flag_r) |-> $past(!resistive_load_output, 2))
    else $error("open load flagged while on");
  a_open_low_level: assert property ( // R2
    $rose(open_load_flag_r) |-> $past(!drain_s, 2))
    else $error("open load flagged without low drain");
  a_drain_follow: assert property ( // R4
    $changed(drain_state_bit) |-> $past(drain_s) == drain_state_bit)
    else $error("drain state moved against comparator");
  a_oc_filter_len: assert property ( // R5
    $rose(oc_filt) |-> oc_run_r == CNT_W'(SHORT_CYC))
    else $error("overcurrent filter length wrong");
  a_oc_shutdown: assert property ( // R5 R6
    $rose(oc_filt) |=> !resistive_load_output && !output_on_cmd_r && overcurrent_flag_r)
    else $error("overcurrent did not shut down");
  a_ot_shutdown: assert property ( // R8 R6
    $rose(ot_filt) |=> !resistive_load_output && !output_on_cmd_r && overtemp_flag_r)
    else $error("overtemperature did not shut down");
  a_ot_hold_flag: assert property ( // R9
    ot_filt && fault_clear_cmd |=> overtemp_flag_r)
    else $error("overtemperature cleared while active");
  a_on_ignored: assert property ( // R10
    ctrl_wr && (overcurrent_flag_r || overtemp_flag_r) |=> !resistive_load_output)
    else $error("on accepted during latched fault");

  c_oc_trip:  cover property ($rose(overcurrent_flag_r));
  c_ot_trip:  cover property ($rose(overtemp_flag_r));
  c_open:     cover property ($rose(open_load_flag_r));
  c_recover:  cover property ($fell(overcurrent_flag_r) ##[1:50] $rose(resistive_load_output));
endmodule // lsd_fault_logic

//--- verilog/lsd_pkg.sv
// Constants for the resistive-load low-side driver control and fault logic
// Function
// (R1) Output transistor switches only as the stored on command orders.
// (R2) Open-load flag sets after output stays below threshold for long filter period.
// (R3) Open-load filtering and flagging happen only while the output is off.
// (R4) Drain state bit follows comparator, both edges filtered by short period.
// (R5) Overcurrent held for short period turns output off and sets flag.
// (R6) Any overcurrent or overtemperature shutdown clears the stored on command.
// (R7) Host restores output by writing fault clear, then a fresh on command.
// (R8) Overtemperature held for short period turns output off and sets flag.
// (R9) Overtemperature clears only once the condition ended; then clear and on.
// (R10) Shutdown flags stay latched until cleared; on commands ignored meanwhile.
package lsd_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STAT_OFS      = 8'h04;
  localparam int         ON_BIT        = 0;
  localparam int         CLR_BIT       = 1;
  localparam int         OPEN_BIT      = 0;
  localparam int         OC_BIT        = 1;
  localparam int         OT_BIT        = 2;
  localparam int         DRAIN_BIT     = 3;
  localparam int         OUT_BIT       = 4;
  localparam logic       ON_RST        = 1'b0;
  localparam logic       FLAG_RST      = 1'b0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int         CLK_MHZ       = 25;
  localparam int         SHORT_US      = 10;
  localparam int         LONG_US       = 100;
  localparam int         SHORT_CYC     = SHORT_US * CLK_MHZ;
  localparam int         LONG_CYC      = LONG_US * CLK_MHZ;
  localparam int         CNT_W         = 12;
endpackage

//--- tb/lsd_wb_host.sv
// Wishbone classic host model standing in for the controlling processor
`timescale 1ns/1ns

module lsd_wb_host
(
  input  wire logic        clk,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // Released address and data lines show the inverse so a stale value is never mistaken for live
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= dat;
    do @(posedge clk); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~dat;
  endtask
endmodule // lsd_wb_host

//--- tb/low_side_driver_fault_logic_bench.sv
// Self-checking bench for the low-side driver command and fault logic
`timescale 1ns/1ns

module low_side_driver_fault_logic_bench;
  import lsd_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc, stb, we, ack, outp;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, junk;
  logic [1:0]  flt_cmp = 2'b00;
  logic        drain_cmp = 1'b1;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          m_on = 0, m_open = 0, m_drain = 0;
  int          m_flt [2] = '{0, 0};

  always #20 clk = ~clk;

  lsd_wb_host host_u (.clk(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));

  lsd_fault_logic dut_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .overcurrent_cmp(flt_cmp[0]), .overtemp_cmp(flt_cmp[1]),
    .drain_above_cmp(drain_cmp), .resistive_load_output(outp));

  // -----------------------------------------------------------------------------
  // Checking helpers
  // -----------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host_u.xfer(1'b0, a, 32'h0, 4'hf, v);
    check($sformatf("read %h", a), exp, v);
  endtask

  // Upper data bits and upper byte enables are random and must be ignored
  task automatic wr(input logic [1:0] val);
    logic [31:0] v;
    host_u.xfer(1'b1, CTRL_OFS, ($urandom() & 32'hfffffffc) | val, {3'($urandom()), 1'b1}, v);
  endtask

  task automatic stat();
    rd(STAT_OFS, 32'(m_on << OUT_BIT | m_drain << DRAIN_BIT | m_flt[1] << OT_BIT
       | m_flt[0] << OC_BIT | m_open << OPEN_BIT));
    check("output pin", 32'(m_on), 32'(outp));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // -----------------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------------
  initial
  begin
    void'($urandom(20077));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CTRL_OFS, 32'h0);
    rd(8'h08, 32'h0);
    // On write without byte lane 0 must not reach the command bit
    host_u.xfer(1'b1, CTRL_OFS, 32'h1, 4'he, junk);
    rd(CTRL_OFS, 32'h0);
    stat();
    repeat (300) @(posedge clk);
    m_drain = 1;
    stat();
    $display("test reset and drain filter done");
    wr(2'b01);
    m_on = 1;
    stat();
    rd(CTRL_OFS, 32'h1);
    drain_cmp <= 1'b0;
    repeat (3000) @(posedge clk);
    m_drain = 0;
    stat();
    wr(2'b00);
    m_on = 0;
    stat();
    repeat (2300) @(posedge clk);
    stat();
    repeat (400) @(posedge clk);
    m_open = 1;
    stat();
    drain_cmp <= 1'b1;
    repeat (300) @(posedge clk);
    m_drain = 1;
    wr(2'b10);
    m_open = 0;
    stat();
    $display("test open load done");
    for (int i = 0; i < 2; i++)
    begin
      wr(2'b01);
      m_on = 1;
      flt_cmp[i] <= 1'b1;
      repeat (200) @(posedge clk);
      stat();
      repeat (100) @(posedge clk);
      m_on = 0;
      m_flt[i] = 1;
      stat();
      wr(2'b10);
      stat();
      flt_cmp[i] <= 1'b0;
      repeat (300) @(posedge clk);
      wr(2'b01);
      stat();
      wr(2'b10);
      m_flt[i] = 0;
      stat();
      wr(2'b01);
      m_on = 1;
      stat();
      wr(2'b00);
      m_on = 0;
      $display("test shutdown fault %0d done", i);
    end
    tally_and_finish();
  end
endmodule // low_side_driver_fault_logic_bench
